// *** design/sleep_sub_pkg.sv ***
// constants and carrier types for the sleep / subtract execution block
// assumes a 14-bit instruction word and an 8-bit data path
package sleep_sub_pkg;
  // opcode patterns
  localparam logic [13:0] OP_SLEEP      = 14'h0063; // low-power entry
  localparam logic [5:0]  OP_SUBLIT_HI  = 6'h3C;    // 11 110x, bit 8 free
  localparam logic [5:0]  OP_SUBFILE_HI = 6'h02;    // 00 0010
  // field positions
  localparam int DEST_BIT    = 7;                   // destination select
  localparam int ADDR_MSB    = 6;                   // 7-bit file address
  localparam int LIT_MSB     = 7;                   // 8-bit literal
  // reset values
  localparam logic [7:0]  ACC_RST      = 8'h00;     // working register
  localparam logic [7:0]  GUARD_CLEAR  = 8'h00;     // guard timer clear
  localparam logic        EXPIRY_RST   = 1'b1;      // expiry flag
  localparam logic        SLEEPENT_RST = 1'b1;      // sleep entry flag

  // arithmetic flags carried together
  typedef struct packed {
    logic carry;        // inverted borrow
    logic digit_borrow; // inverted nibble borrow
    logic zero;         // result is zero
  } alu_flags_t;

  // file register write request
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

  // executed operation, one-hot
  typedef enum logic [3:0] {
    EX_NONE  = 4'b0001,
    EX_SLEEP = 4'b0010,
    EX_SUBL  = 4'b0100,
    EX_SUBF  = 4'b1000
  } exec_op_t;
endpackage

// *** design/sleep_sub_exec.sv ***
// execution of sleep, literal-subtract and file-subtract instructions
// assumes the fetch unit presents a raw instruction word with INSTR_VALID and the
// register file returns the addressed byte on FILE_RDATA combinationally
//
// Overview of operation
// - sleep clears sleep-entry flag, sets expiry flag
// - sleep clears guard timer and prescaler
// - sleep halts core until wake-up
// - literal minus accumulator into accumulator, flags
// - file minus accumulator, 7-bit address, flags
// - destination zero writes accumulator only
// - destination one writes file only
// - carry set unless difference negative
module sleep_sub_exec
  import sleep_sub_pkg::*;
(
  input  wire logic        REF_CLK,      // core clock
  input  wire logic        SRST,         // sync reset, high
  input  wire logic        CE,           // clock enable
  input  wire logic        INSTR_VALID,  // instruction word present
  input  wire logic [13:0] INSTR,        // instruction word
  input  wire logic [7:0]  FILE_RDATA,   // addressed file byte
  input  wire logic        WAKE,         // wake-up event
  output logic [6:0]       FILE_ADDR,    // read address, registered
  output file_wr_t         FILE_WR,      // write-back request
  output logic [7:0]       ACC,          // working register
  output alu_flags_t       FLAGS,        // carry, digit borrow, zero
  output logic             EXPIRY_FLAG,  // expiry status bit
  output logic             SLEEP_ENTRY_FLAG, // sleep entry status bit
  output logic             GUARD_CLR,    // guard timer/prescaler clear
  output logic             SLEEPING      // oscillator halted
);

  // decode of the current word
  exec_op_t   op;           // operation to execute
  logic [7:0] minuend;      // literal or file byte
  logic [8:0] diff9;        // difference with borrow-out
  logic [4:0] low5;         // low-nibble difference
  logic       go;           // execution allowed this cycle

  // sleeping core executes nothing
  assign go = CE && INSTR_VALID && !SLEEPING;

  // decode, plain one-hot selection
  always_comb begin
    op = EX_NONE;
    if (go) begin
      if (INSTR == OP_SLEEP) begin
        op = EX_SLEEP;
      end else if (INSTR[13:8] == OP_SUBFILE_HI) begin
        op = EX_SUBF;
      end else if (INSTR[13:9] == OP_SUBLIT_HI[5:1]) begin
        op = EX_SUBL;
      end
    end
  end

  // operand select: literal or addressed file byte
  assign minuend = (op == EX_SUBL) ? INSTR[LIT_MSB:0] : FILE_RDATA;

  // two's complement subtract, bit 8 is the borrow
  assign diff9 = {1'b0, minuend} - {1'b0, ACC};
  assign low5  = {1'b0, minuend[3:0]} - {1'b0, ACC[3:0]};

  // working register update
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ACC <= ACC_RST;
    end else if (CE) begin
      case (op)
        EX_SUBL: ACC <= diff9[7:0];
        EX_SUBF: begin
          if (!INSTR[DEST_BIT]) ACC <= diff9[7:0];
        end
        default: ACC <= ACC;
      endcase
    end
  end

  // file write-back, one-cycle request
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      FILE_WR <= '0;
    end else if (CE) begin
      FILE_WR.wr   <= (op == EX_SUBF) && INSTR[DEST_BIT];
      FILE_WR.addr <= INSTR[ADDR_MSB:0];
      FILE_WR.data <= diff9[7:0];
    end
  end

  // read address mirror for the register file
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      FILE_ADDR <= '0;
    end else if (CE && go) begin
      FILE_ADDR <= INSTR[ADDR_MSB:0];
    end
  end

  // arithmetic flags, both subtracts
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      FLAGS <= '0;
    end else if (CE && (op == EX_SUBL || op == EX_SUBF)) begin
      FLAGS.carry        <= ~diff9[8];
      FLAGS.digit_borrow <= ~low5[4];
      FLAGS.zero         <= (diff9[7:0] == 8'h00);
    end
  end

  // status bits on sleep entry
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      EXPIRY_FLAG      <= EXPIRY_RST;
      SLEEP_ENTRY_FLAG <= SLEEPENT_RST;
    end else if (CE && op == EX_SLEEP) begin
      EXPIRY_FLAG      <= 1'b1;
      SLEEP_ENTRY_FLAG <= 1'b0;
    end
  end

  // guard timer clear pulse, one cycle
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      GUARD_CLR <= 1'b0;
    end else if (CE) begin
      GUARD_CLR <= (op == EX_SLEEP);
    end
  end

  // sleep state; wake is from logic on this clock, the
  // oscillator gating itself lives outside this block
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      SLEEPING <= 1'b0;
    end else if (CE) begin
      if (op == EX_SLEEP) begin
        SLEEPING <= 1'b1;
      end else if (WAKE) begin
        SLEEPING <= 1'b0;
      end
    end
  end

  // assertions
  // each arithmetic check restates a rule from the operands of the executed word,
  // except chk_zero_flag, which compares against the registered FILE_WR.data
  // sleep entry: expiry flag set and sleep-entry flag cleared in the cycle after the word
  chk_sleep_status: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && op == EX_SLEEP) |=> EXPIRY_FLAG && !SLEEP_ENTRY_FLAG)
    else $error("sleep did not update status bits");
  chk_guard_clear: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && op == EX_SLEEP) |=> GUARD_CLR)
    else $error("guard clear not pulsed on sleep");
  // guard clear is a pulse, never a level
  chk_guard_pulse: assert property (@(posedge REF_CLK) disable iff (SRST)
    GUARD_CLR |=> !GUARD_CLR)
    else $error("guard clear held longer than one cycle");
  // halted core: an offered word neither changes ACC nor raises FILE_WR.wr or GUARD_CLR
  chk_sleep_halt: assert property (@(posedge REF_CLK) disable iff (SRST)
    SLEEPING |=> $stable(ACC) && !FILE_WR.wr && !GUARD_CLR)
    else $error("instruction executed while asleep");
  chk_lit_result: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && op == EX_SUBL) |=>
      ACC == $past(INSTR[7:0]) - $past(ACC))
    else $error("literal subtract result wrong");
  chk_file_addr: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && op == EX_SUBF) |=> FILE_WR.addr == $past(INSTR[6:0]))
    else $error("file address field wrong");
  chk_dest_acc: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && op == EX_SUBF && !INSTR[7]) |=>
      !FILE_WR.wr && ACC == $past(FILE_RDATA) - $past(ACC))
    else $error("destination zero misrouted");
  chk_dest_file: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && op == EX_SUBF && INSTR[7]) |=>
      FILE_WR.wr && $stable(ACC))
    else $error("destination one misrouted");
  chk_carry_borrow: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && op == EX_SUBL) |=>
      FLAGS.carry == ($past(INSTR[7:0]) >= $past(ACC)))
    else $error("carry not inverted borrow");
  chk_zero_flag: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && (op == EX_SUBL || op == EX_SUBF)) |=>
      FLAGS.zero == (FILE_WR.data == 8'h00))
    else $error("zero flag wrong");
  // file subtract uses the same inverted-borrow carry
  chk_file_carry: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && op == EX_SUBF) |=>
      FLAGS.carry == ($past(FILE_RDATA) >= $past(ACC)))
    else $error("file carry not inverted borrow");
  // low nibble: flag high when no nibble borrow occurs
  chk_digit_flag: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && op == EX_SUBL) |=>
      FLAGS.digit_borrow == ($past(INSTR[3:0]) >= $past(ACC[3:0])))
    else $error("digit flag wrong");
  // a sleep word leaves the arithmetic flags alone
  chk_sleep_flags: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && op == EX_SLEEP) |=> $stable(FLAGS))
    else $error("flags changed by sleep");
  // cover points for the main scenarios
  cov_sleep: cover property (@(posedge REF_CLK) CE && op == EX_SLEEP);
  cov_subl_neg: cover property (@(posedge REF_CLK)
    CE && op == EX_SUBL && diff9[8]);
  cov_subf_file: cover property (@(posedge REF_CLK)
    CE && op == EX_SUBF && INSTR[7]);
  cov_wake: cover property (@(posedge REF_CLK) SLEEPING ##1 !SLEEPING);
  cov_subf_acc: cover property (@(posedge REF_CLK)
    CE && op == EX_SUBF && !INSTR[7]);
endmodule // sleep_sub_exec

// *** bench/file_model.sv ***
// behavioural register file on the far side of the execution block
// assumes reads are combinational and writes land on the rising edge
module file_model
  import sleep_sub_pkg::*;
(
  input  wire logic       clk,     // core clock
  input  wire logic [6:0] rd_addr, // address field of the word
  input  wire file_wr_t   wr,      // write-back request
  output logic [7:0]      rdata    // addressed byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128]; // 7-bit address space
  // spread of values so nibble borrows occur
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
  // read path stays valid all cycle, no hold window
  assign rdata = mem[rd_addr];
  // write-back only on the request pulse
  always @(posedge clk) if (wr.wr) mem[wr.addr] <= wr.data;
endmodule // file_model

// *** bench/sleep_sub_exec_test.sv ***
// self-checking bench for the sleep / subtract execution block
// assumes file_model answers reads and takes write-backs
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
  error_cnt++; $display("mismatch at %0t: %s", $time, m); end end
module sleep_sub_exec_test;
  import sleep_sub_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, srst, ce, valid, wake;  // driven inputs
  logic [13:0] instr;                           // instruction word
  logic [7:0]  rdata, acc, exp_acc;             // data and model
  logic [6:0]  faddr;                           // registered read address copy, checked
  file_wr_t    fwr;                             // write-back
  alu_flags_t  flags;                           // arithmetic flags
  logic        expiry, sleep_ent, gclr, sleeping; // status
  logic [10:0] r;                               // {c,dc,z,result}
  int          error_cnt, check_count;          // counters
  sleep_sub_exec i_sleep_sub_exec (.REF_CLK(ref_clk), .SRST(srst),
    .CE(ce), .INSTR_VALID(valid), .INSTR(instr), .FILE_RDATA(rdata),
    .WAKE(wake), .FILE_ADDR(faddr), .FILE_WR(fwr), .ACC(acc),
    .FLAGS(flags), .EXPIRY_FLAG(expiry), .SLEEP_ENTRY_FLAG(sleep_ent),
    .GUARD_CLR(gclr), .SLEEPING(sleeping));
  file_model i_file_model (.clk(ref_clk), .rd_addr(instr[6:0]),
    .wr(fwr), .rdata(rdata));
  // 25 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // reference subtract a - b with inverted borrows
  function automatic logic [10:0] sub8(input logic [7:0] a, b);
    logic [8:0] d;
    logic [4:0] n;
    d = {1'b0, a} - {1'b0, b};
    n = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    return {~d[8], ~n[4], d[7:0] == 8'h00, d[7:0]};
  endfunction
  // present a word; valid stays up for back-to-back use
  task go(input logic [13:0] w);
    instr = w;
    valid = 1'b1;
    @(posedge ref_clk);
    #1;
  endtask
  task idle();
    valid = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  task t_sublit();
    logic [7:0] ks [6];
    ks = '{8'h03, 8'h02, 8'h01, 8'h10, 8'h0E, 8'hFF};
    // back-to-back chain, bit 8 toggled since it is ignored
    foreach (ks[i]) begin
      r = sub8(ks[i], exp_acc);
      go({5'h1E, 1'(i), ks[i]});
      `CHK(acc, r[7:0], "literal result")
      `CHK(flags, r[10:8], "literal flags")
      exp_acc = r[7:0];
    end
    ce = 1'b0;
    go(14'h3C55);
    `CHK(acc, exp_acc, "frozen while disabled")
    ce = 1'b1;
    idle();
  endtask
  task t_subfile(input logic [6:0] a, input logic d);
    logic [7:0] f;
    f = i_file_model.mem[a];
    r = sub8(f, exp_acc);
    go({6'h02, d, a});
    `CHK(flags, r[10:8], "file flags")
    `CHK(fwr.wr, d, "write strobe")
    `CHK(faddr, a, "read address copy")
    if (d) begin
      `CHK(fwr.addr, a, "write address")
      `CHK(fwr.data, r[7:0], "write data")
      `CHK(acc, exp_acc, "acc kept")
    end else begin
      `CHK(acc, r[7:0], "acc result")
      exp_acc = r[7:0];
    end
    idle();
    `CHK(fwr.wr, 1'b0, "strobe one cycle")
    `CHK(i_file_model.mem[a], d ? r[7:0] : f, "file content")
  endtask
  task t_sleep();
    int n;
    go(OP_SLEEP);
    `CHK(sleeping, 1'b1, "halted")
    `CHK(gclr, 1'b1, "guard clear")
    `CHK(expiry, 1'b1, "expiry set")
    `CHK(sleep_ent, 1'b0, "entry cleared")
    // a word offered while halted must be ignored
    go({5'h1E, 1'b0, 8'h77});
    `CHK(gclr, 1'b0, "clear is a pulse")
    `CHK(acc, exp_acc, "no execution asleep")
    idle();
    wake = 1'b1;
    n = 0;
    while (sleeping === 1'b1 && n < 10) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    wake = 1'b0;
    `CHK(sleeping, 1'b0, "woken within bound")
    r = sub8(8'h40, exp_acc);
    go({5'h1E, 1'b1, 8'h40});
    `CHK(acc, r[7:0], "runs after wake")
    idle();
  endtask
  task wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    {srst, ce, valid, wake, instr} = {3'b110, 1'b0, 14'h0000};
    {exp_acc, error_cnt, check_count} = '0;
    repeat (6) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    `CHK({acc, flags, fwr, expiry, sleep_ent, gclr, sleeping},
      {8'h00, 3'b000, 16'h0000, 4'b1100}, "reset values")
    t_sublit();
    t_subfile(7'h00, 1'b0);
    t_subfile(7'h7F, 1'b1);
    t_subfile(7'h7F, 1'b0);
    t_subfile(7'h2A, 1'b1);
    t_sleep();
    wrap_up();
  end
endmodule // sleep_sub_exec_test
